// *** hw/ccm_pkg.sv ***
// ccm_pkg: constants and carrier types for the can control/identifier block
// assumes a 32-bit axi4-lite register face and a 50 mhz bus clock
package ccm_pkg;

  // ---------------------------------------------------------------------
  // register window
  // ---------------------------------------------------------------------
  localparam int unsigned WIN_BYTES   = 64;
  localparam logic [5:0]  IDX_ID0     = 6'h00; // id_byte_0 index
  localparam logic [5:0]  IDX_ID1     = 6'h01;
  localparam logic [5:0]  IDX_ID2     = 6'h02;
  localparam logic [5:0]  IDX_ID3     = 6'h03;
  localparam logic [5:0]  IDX_CTL0    = 6'h04; // controller_control_0 index
  localparam logic [5:0]  IDX_TSTAMP  = 6'h05; // time stamp (bytes e/f)
  localparam logic [5:0]  IDX_TIMER   = 6'h06; // live timer value
  localparam logic [5:0]  IDX_LIMIT   = 6'h0f; // last word index in the 64-byte window

  // ---------------------------------------------------------------------
  // control register 0 field positions and reset
  // ---------------------------------------------------------------------
  localparam int unsigned B_FRAME  = 7;
  localparam int unsigned B_RXBUSY = 6;
  localparam int unsigned B_SWAI   = 5;
  localparam int unsigned B_SYNC   = 4;
  localparam int unsigned B_TIME   = 3;
  localparam int unsigned B_WAKE   = 2;
  localparam int unsigned B_SLEEP  = 1;
  localparam int unsigned B_INIT   = 0;
  localparam logic [7:0]  CTL0_RST = 8'h01; // init request set at reset

  // identifier layouts, bus response codes and recessive bus level
  localparam int unsigned STD_ID_BITS = 13;
  localparam int unsigned EXT_ID_BITS = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic        BUS_RECESSIVE = 1'b1;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic        rx_active;   // receiver front end busy
    logic        synced;      // bus synchronised
    logic        frame_ok;    // one-cycle pulse: valid frame at eof
    logic        is_receive;  // frame was a receive
    logic        bit_tick;    // one-cycle pulse per bit time
    logic        loopback;    // loopback mode active
    logic        init_ack;    // init acknowledge
    logic        tx_bit;      // 1 recessive, 0 dominant
  } ccm_link_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WR   = 3'b010,
    ST_RESP = 3'b100
  } ccm_wst_t;

endpackage

// *** hw/ccm_timer.sv ***
// ccm_timer: 16-bit free-running bit-time counter with stamp capture
// assumes bit_tick is a one-cycle pulse in the aclk domain
`timescale 1ns/1ps
`default_nettype none
module ccm_timer (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        enable,
  input  wire logic        bit_tick,
  input  wire logic        capture,
  // results
  output var  logic [15:0] count,
  output var  logic [15:0] stamp
);
  import ccm_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] stp;
  } ccm_tmr_t;

  ccm_tmr_t s_q, s_d;

  // next state: count, clear when off, grab stamp at eof
  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d.cnt = 16'h0000;                    // [RULE11]
    end else if (bit_tick) begin
      s_d.cnt = s_q.cnt + 16'h0001;          // [RULE9]
    end
    if (enable && capture) begin
      s_d.stp = s_q.cnt;                     // [RULE10]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign stamp = s_q.stp;

  property p_clear_when_off;
    @(posedge aclk) disable iff (!aresetn)
      !enable |=> (count == 16'h0000);
  endproperty
  a_clear_when_off: assert property (p_clear_when_off) // [RULE11]
    else $error("timer not cleared while disabled");

  property p_tick_adv;
    @(posedge aclk) disable iff (!aresetn)
      enable && bit_tick ##1 enable |-> count == $past(count) + 16'h0001;
  endproperty
  a_tick_adv: assert property (p_tick_adv) // [RULE9]
    else $error("timer did not advance on bit tick");

endmodule
`default_nettype wire

// *** hw/ccm_top.sv ***
// ccm_top: control register 0 and identifier bytes of a can controller
// assumes an axi4-lite master and a can core that provides link status
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE1] registers decode in a fixed 64-byte window from offset zero.
// [RULE2] control 0 is writable outside init; status bits are read-only.
// [RULE3] in init mode control 0 holds reset except wakeup, init, sleep.
// [RULE4] the received-frame flag sets on valid frames, clears on write 1.
// [RULE5] received-frame and receiver-active are meaningless in loopback.
// [RULE6] receiver-active follows the receive front end.
// [RULE7] stop-in-wait gates the bus interface clock during wait mode.
// [RULE8] synchronised status mirrors the core's bus synchronisation.
// [RULE9] the timer enable starts a 16-bit counter at the bit rate.
// [RULE10] the counter is stored as a stamp right after each valid eof.
// [RULE11] the timer clears when disabled and its enable is low in init.
// [RULE12] software writes transmit buffers only when empty and selected; the identifier bytes here take writes at any time.
// [RULE13] identifier bytes have no defined reset value.
// [RULE14] a standard identifier spans 13 bits in bytes 0 and 1.
// [RULE15] an extended identifier spans all 32 bits of bytes 0 to 3.
// [RULE16] the transmit pin drives 0 dominant and 1 recessive.
// [RULE17] unused standard-format bits read undefined, never affect frames.
module ccm_top (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [5:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [5:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // can core side
  input  wire ccm_pkg::ccm_link_t link,
  input  wire logic              wait_mode,
  output var  logic              bus_transmit_pin,
  output var  logic              iface_clk_en,
  output var  logic              init_request,
  output var  logic              sleep_request,
  output var  logic              wakeup_enable,
  output var  logic              timer_enable,
  output var  logic [31:0]       id_word,
  output var  logic              ext_format
);
  import ccm_pkg::*;

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  typedef struct packed {
    ccm_wst_t    wst;
    logic        aw_have;
    logic [5:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        frame_flg;
    logic        swai;
    logic        time_en;
    logic        wake_en;
    logic        sleep_rq;
    logic        init_rq;
    logic        rx_busy;
    logic        sync;
    logic [31:0] idr;
    logic        txpin;
    logic        clken;
  } ccm_state_t;

  ccm_state_t s_q, s_d;
  logic [15:0] tmr_count;
  logic [15:0] tmr_stamp;
  logic        in_init;
  logic [7:0]  ctl0_view;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic        wr_fire;
  logic        wr_c0;
  logic        frm_set;

  // -----------------------------------------------------------------------
  // time stamp counter
  // -----------------------------------------------------------------------
  ccm_timer u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (s_q.time_en),
    .bit_tick (link.bit_tick),
    .capture  (link.frame_ok),
    .count    (tmr_count),
    .stamp    (tmr_stamp)
  );

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  assign in_init   = s_q.init_rq && link.init_ack;        // [RULE3]
  assign wr_idx    = {2'b00, s_q.aw_addr[5:2]};           // [RULE1]
  assign rd_idx    = {2'b00, s_axi_araddr[5:2]};
  assign wr_fire   = (s_q.wst == ST_WR);
  assign wr_c0     = wr_fire && (wr_idx == IDX_CTL0) && s_q.w_strb[0];
  assign frm_set   = link.frame_ok && link.is_receive && !link.loopback;
  assign ctl0_view = {s_q.frame_flg, s_q.rx_busy, s_q.swai, s_q.sync,
                      s_q.time_en, s_q.wake_en, s_q.sleep_rq, s_q.init_rq};

  // next state of the bus slave and control register
  always_comb begin
    s_d = s_q;
    // write address and data taken in either order
    if (s_axi_awvalid && !s_q.aw_have && s_q.wst == ST_IDLE) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_have && s_q.wst == ST_IDLE) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    unique case (s_q.wst)
      ST_IDLE: begin
        if (s_q.aw_have && s_q.w_have) begin
          s_d.wst = ST_WR;
        end
      end
      ST_WR: begin
        s_d.wst     = ST_RESP;
        s_d.aw_have = 1'b0;
        s_d.w_have  = 1'b0;
        s_d.bresp   = (wr_idx <= IDX_LIMIT) ? RESP_OKAY : RESP_SLVERR;
      end
      ST_RESP: begin
        if (s_axi_bready) begin
          s_d.wst = ST_IDLE;
        end
      end
    endcase
    // identifier bytes, per byte lane
    for (int i = 0; i < 4; i++) begin
      if (wr_fire && wr_idx == IDX_ID0 && s_q.w_strb[i]) begin
        s_d.idr[8*i +: 8] = s_q.w_data[8*i +: 8];        // [RULE15]
      end
    end
    // control 0 software writes
    if (wr_c0) begin
      s_d.init_rq = s_q.w_data[B_INIT];                   // [RULE2]
      if (!in_init) begin
        s_d.swai     = s_q.w_data[B_SWAI];
        s_d.time_en  = s_q.w_data[B_TIME];
        s_d.wake_en  = s_q.w_data[B_WAKE];
        s_d.sleep_rq = s_q.w_data[B_SLEEP];
      end
      if (s_q.w_data[B_FRAME]) begin
        s_d.frame_flg = 1'b0;                             // [RULE4]
      end
    end
    // status from the core
    s_d.rx_busy = link.rx_active && !link.loopback;      // [RULE5] [RULE6]
    s_d.sync    = link.synced;                            // [RULE8]
    if (frm_set) begin
      s_d.frame_flg = 1'b1;                               // [RULE4]
    end
    // init mode holds the rest at reset
    if (in_init) begin
      s_d.frame_flg = 1'b0;                               // [RULE3]
      s_d.rx_busy   = 1'b0;
      s_d.swai    = 1'b0;
      s_d.sync    = 1'b0;
      s_d.time_en = 1'b0;                                 // [RULE11]
    end
    s_d.txpin = link.tx_bit;                              // [RULE16]
    s_d.clken = !(s_q.swai && wait_mode);                 // [RULE7]
    // read channel, one read at a time
    if (s_q.rvalid) begin
      if (s_axi_rready) begin
        s_d.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      unique case (rd_idx)
        IDX_ID0:    s_d.rdata = s_q.idr;                  // [RULE14] [RULE17]
        IDX_CTL0:   s_d.rdata = {24'h00_0000, ctl0_view};
        IDX_TSTAMP: s_d.rdata = {16'h0000, tmr_stamp};    // [RULE10]
        IDX_TIMER:  s_d.rdata = {16'h0000, tmr_count};
        default: begin
          if (rd_idx > IDX_LIMIT) begin
            s_d.rresp = RESP_SLVERR;
          end
        end
      endcase
    end
  end

  // registers; identifier bytes keep no reset value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.wst     <= ST_IDLE;
      s_q.aw_have <= 1'b0;
      s_q.aw_addr <= 6'h00;
      s_q.w_have  <= 1'b0;
      s_q.w_data  <= 32'h0000_0000;
      s_q.w_strb  <= 4'h0;
      s_q.bresp   <= RESP_OKAY;
      s_q.rvalid  <= 1'b0;
      s_q.rdata   <= 32'h0000_0000;
      s_q.rresp   <= RESP_OKAY;
      {s_q.frame_flg, s_q.rx_busy, s_q.swai, s_q.sync,
       s_q.time_en, s_q.wake_en, s_q.sleep_rq, s_q.init_rq} <= CTL0_RST;
      s_q.txpin   <= BUS_RECESSIVE;
      s_q.clken   <= 1'b1;
      s_q.idr     <= s_d.idr;                             // [RULE13]
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  assign s_axi_awready    = (s_q.wst == ST_IDLE) && !s_q.aw_have;
  assign s_axi_wready     = (s_q.wst == ST_IDLE) && !s_q.w_have;
  assign s_axi_bvalid     = (s_q.wst == ST_RESP);
  assign s_axi_bresp      = s_q.bresp;
  assign s_axi_arready    = !s_q.rvalid;
  assign s_axi_rvalid     = s_q.rvalid;
  assign s_axi_rdata      = s_q.rdata;
  assign s_axi_rresp      = s_q.rresp;
  assign bus_transmit_pin = s_q.txpin;
  assign iface_clk_en     = s_q.clken;
  assign init_request     = s_q.init_rq;
  assign sleep_request    = s_q.sleep_rq;
  assign wakeup_enable    = s_q.wake_en;
  assign timer_enable     = s_q.time_en;
  assign id_word          = s_q.idr;
  assign ext_format       = s_q.idr[11];                  // [RULE14]

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  property p_frm_sets;
    @(posedge aclk) disable iff (!aresetn)
      frm_set && !in_init |=> s_q.frame_flg;
  endproperty
  a_frm_sets: assert property (p_frm_sets) // [RULE4]
    else $error("received-frame flag missed a frame");

  property p_frm_zero_keeps;
    @(posedge aclk) disable iff (!aresetn)
      wr_c0 && !s_q.w_data[B_FRAME] && s_q.frame_flg && !in_init
        |=> s_q.frame_flg;
  endproperty
  a_frm_zero_keeps: assert property (p_frm_zero_keeps) // [RULE4]
    else $error("writing zero cleared received-frame flag");

  property p_init_hold;
    @(posedge aclk) disable iff (!aresetn)
      in_init ##1 in_init |-> !s_q.time_en && !s_q.swai && !s_q.frame_flg;
  endproperty
  a_init_hold: assert property (p_init_hold) // [RULE3]
    else $error("control 0 not held in init");

  property p_init_nowrite;
    @(posedge aclk) disable iff (!aresetn)
      wr_c0 && in_init |=> s_q.wake_en == $past(s_q.wake_en);
  endproperty
  a_init_nowrite: assert property (p_init_nowrite) // [RULE2]
    else $error("control 0 written during init");

  property p_receiver_active_status;
    @(posedge aclk) disable iff (!aresetn)
      link.rx_active && !link.loopback && !in_init |=> s_q.rx_busy;
  endproperty
  a_receiver_active_status: assert property (p_receiver_active_status) // [RULE6]
    else $error("receiver-active not following front end");

  property p_loop;
    @(posedge aclk) disable iff (!aresetn)
      link.loopback |=> !s_q.rx_busy;
  endproperty
  a_loop: assert property (p_loop) // [RULE5]
    else $error("receiver-active set in loopback");

  property p_sync;
    @(posedge aclk) disable iff (!aresetn)
      !in_init |=> s_q.sync == $past(link.synced);
  endproperty
  a_sync: assert property (p_sync) // [RULE8]
    else $error("sync status wrong");

  property p_wait_gate;
    @(posedge aclk) disable iff (!aresetn)
      s_q.swai && wait_mode |=> !iface_clk_en;
  endproperty
  a_wait_gate: assert property (p_wait_gate) // [RULE7]
    else $error("interface clock not stopped in wait");

  property p_txpin;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> bus_transmit_pin == $past(link.tx_bit);
  endproperty
  a_txpin: assert property (p_txpin) // [RULE16]
    else $error("transmit pin does not follow core bit");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) // [RULE1]
    else $error("write response late");

  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_read:  cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_frame: cover property (@(posedge aclk) frm_set);
  c_init:  cover property (@(posedge aclk) in_init);

endmodule
`default_nettype wire

// *** verif/ccm_link_model.sv ***
// ccm_link_model: behavioural can core and bus station for the bench
// assumes the bench calls its tasks from one thread, just after clock edges
`timescale 1ns/1ps
`default_nettype none
module ccm_link_model (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // device side
  input  wire logic               init_request,
  output var  ccm_pkg::ccm_link_t link
);
  import ccm_pkg::*;

  // ---------------------------------------------------------------------
  // levels and acknowledge
  // ---------------------------------------------------------------------
  initial link = 8'h01;

  // init acknowledge follows the request one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      link <= 8'h01; // recessive idle
    end else begin
      link.init_ack <= init_request;
    end
  end

  // bus levels seen by the core
  task automatic set_lvl(input logic sync, input logic lb, input logic tx);
    @(posedge aclk);
    link.synced   <= sync;
    link.loopback <= lb;
    link.tx_bit   <= tx;   // 0 dominant, 1 recessive
  endtask

  // one-cycle bit clock pulses, one per bit time
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk) link.bit_tick <= 1'b1;
      @(posedge aclk) link.bit_tick <= 1'b0;
    end
  endtask

  // receive front end becomes busy
  task automatic begin_rx();
    @(posedge aclk);
    link.rx_active  <= 1'b1;
    link.is_receive <= 1'b1;
  endtask

  // end of a valid frame, received or transmitted
  task automatic end_frame(input logic rx);
    @(posedge aclk);
    link.is_receive <= rx;
    link.frame_ok   <= 1'b1;
    @(posedge aclk);
    link.frame_ok   <= 1'b0;
    link.rx_active  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verif/tb_can_control_and_message_id.sv ***
// tb_can_control_and_message_id: self-checking bench for ccm_top
// assumes ccm_link_model as the can core and a 50 mhz aclk
`timescale 1ns/1ps
`default_nettype none
module tb_can_control_and_message_id;
  import ccm_pkg::*;

  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  localparam logic [5:0] A_ID   = {IDX_ID0[3:0], 2'b00};
  localparam logic [5:0] A_CTL  = {IDX_CTL0[3:0], 2'b00};
  localparam logic [5:0] A_STMP = {IDX_TSTAMP[3:0], 2'b00};
  localparam logic [5:0] A_TMR  = {IDX_TIMER[3:0], 2'b00};
  logic        aclk = 1'b0, aresetn = 1'b0, wait_mode = 1'b0;
  logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, bus_transmit_pin, iface_clk_en;
  logic        init_request, sleep_request, wakeup_enable, timer_enable;
  logic        ext_format;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, id_word, id;
  ccm_link_t   link;
  logic [31:0] rq[$];
  logic [1:0]  bq[$];
  int          miscompares = 0, n_compared = 0, cyc = 0;

  always #10 aclk = ~aclk;

  ccm_top i_ccm_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link, .wait_mode, .bus_transmit_pin,
    .iface_clk_en, .init_request, .sleep_request, .wakeup_enable,
    .timer_enable, .id_word, .ext_format
  );

  ccm_link_model i_ccm_link_model (.aclk, .aresetn, .init_request, .link);

  // ---------------------------------------------------------------------
  // compares, bus tasks, verdict
  // ---------------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    bq.push_back(RESP_OKAY);
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  // read: expected word noted in the queue for the monitor
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    rq.push_back(e);
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // monitor: oldest note against each answer
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      cmp_word(s_axi_rdata, rq.pop_front());
      cmp_resp(s_axi_rresp, RESP_OKAY);
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      cmp_resp(s_axi_bresp, bq.pop_front());
    end
  end

  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(90));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_bit(bus_transmit_pin, 1'b1);
    cmp_bit(iface_clk_en, 1'b1);
    rd(A_CTL, 32'h01);
    // init mode: only the init request takes a write
    wr(A_CTL, 32'hef, 4'h1);
    rd(A_CTL, 32'h01);
    cmp_bit(timer_enable, 1'b0);
    wr(A_CTL, 32'h00, 4'h1);
    wr(A_CTL, 32'h2c, 4'h1);
    rd(A_CTL, 32'h2c);
    cmp_bit(timer_enable, 1'b1);
    cmp_bit(wakeup_enable, 1'b1);
    cmp_bit(init_request, 1'b0);
    // received frame while synchronised, flag clear by one only
    i_ccm_link_model.set_lvl(1'b1, 1'b0, 1'b1);
    i_ccm_link_model.begin_rx();
    rd(A_CTL, 32'h7c);
    i_ccm_link_model.end_frame(1'b1);
    rd(A_CTL, 32'hbc);
    wr(A_CTL, 32'h3c, 4'h1);
    rd(A_CTL, 32'hbc);
    wr(A_CTL, 32'hac, 4'h1);
    rd(A_CTL, 32'h3c);
    // stamp of a transmitted frame after five bit times
    i_ccm_link_model.ticks(5);
    i_ccm_link_model.end_frame(1'b0);
    rd(A_STMP, 32'h5);
    i_ccm_link_model.ticks(3);
    rd(A_TMR, 32'h8);
    rd(A_CTL, 32'h3c);
    wr(A_CTL, 32'h24, 4'h1);
    rd(A_TMR, 32'h0);
    // loopback hides receive status
    i_ccm_link_model.set_lvl(1'b1, 1'b1, 1'b1);
    i_ccm_link_model.begin_rx();
    rd(A_CTL, 32'h34);
    i_ccm_link_model.end_frame(1'b1);
    rd(A_CTL, 32'h34);
    // wait mode with and without stop-in-wait
    wait_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp_bit(iface_clk_en, 1'b0);
    wr(A_CTL, 32'h04, 4'h1);
    repeat (3) @(posedge aclk);
    cmp_bit(iface_clk_en, 1'b1);
    wait_mode <= 1'b0;
    // dominant level reaches the transmit pin
    i_ccm_link_model.set_lvl(1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge aclk);
    cmp_bit(bus_transmit_pin, 1'b0);
    // identifier word, whole and a single lane
    id = $urandom();
    // the identifier bytes take the write at any time, idle core or not
    wr(A_ID, id, 4'hf);
    rd(A_ID, id);
    cmp_word(id_word, id);
    cmp_bit(ext_format, id[11]);
    wr(A_ID, 32'h5a5a5a5a, 4'h2);
    id[15:8] = 8'h5a;
    rd(A_ID, id);
    cmp_bit(ext_format, 1'b1);
    // sleep request is a plain control bit outside init
    wr(A_CTL, 32'h02, 4'h1);
    rd(A_CTL, 32'h12);
    cmp_bit(sleep_request, 1'b1);
    cmp_bit(wakeup_enable, 1'b0);
    // unmapped places inside the window
    wr(6'h20, 32'hffffffff, 4'hf);
    rd(6'h20, 32'h0);
    rd(6'h3c, 32'h0);
    repeat (2) @(posedge aclk);
    stop_test();
  end
endmodule
`default_nettype wire
